// >>> src/hpm_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "hpm_regs.svh"

// Notes on behaviour
// - outside hardware mode, interrupt pin pulled low, open drain, while an unmasked event is pending
// - rising edge of tristate/reset pin restores register defaults
// - tristate/reset high releases every driven pin; host keeps it low normally
// - interface select: 00 mux, 01 nonmux, 10 serial, 11 hardware mode
// - nonmux mode: shared pins are data bits 7..0
// - mux mode: shared pins are time shared address/data bits 7..0
// - hardware mode: shared bit 7 disables rx termination, bit 6 tx termination
// - hardware mode: rx mode bits 1,0,2 from shared bits 5,4,1
// - hardware mode: tx mode bits 1,2 from dedicated bits 1,2, bit 0 from the a5_cpol_in pin
// - hardware mode: shared bit 3 picks tx sync function, bit 2 rx sync
// - serial mode: clock on bit 2, data in on bit 1, data out on bit 0
// - hardware mode: tx clock source from shared bit 0 and a dedicated bit 1 input
// - serial mode: address pins strap clock polarity and phase
module hpm_pin_mux
  import hpm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] ad_in,
  output logic [7:0] ad_out,
  output logic [7:0] ad_oe,
  input wire logic int_n_in,
  output logic int_n_out,
  output logic int_n_oe,
  input wire logic [1:0] bus_iface_sel,
  input wire logic tristate_reset_pin,
  input wire logic a5_cpol_in,
  input wire logic a4_cpha_in,
  input wire logic tx_mode_sel_b1,
  input wire logic tx_mode_sel_b2,
  input wire logic tx_clk_src_sel_b1,
  input wire logic [7:0] par_rd_data,
  input wire logic par_drive,
  input wire logic spi_miso,
  input wire logic [`HPM_ALARM_W-1:0] alarm_evt,
  output logic [1:0] iface_mode,
  output logic [7:0] bus_data,
  output logic spi_sclk_sample,
  output logic spi_sclk_shift,
  output logic spi_mosi,
  output logic rx_term_disable,
  output logic tx_term_disable,
  output logic [2:0] rx_mode_sel,
  output logic [2:0] tx_mode_sel,
  output logic tx_sync_fn_sel,
  output logic rx_sync_fn_sel,
  output logic [1:0] tx_clk_src_sel,
  output logic jitter_clk_sel
);

  hpm_state_t s;
  hpm_state_t n;
  logic [`HPM_SY_W-1:0] pins;
  logic tst;
  logic tst_rise;
  logic [1:0] bis;
  logic ap;
  logic [`HPM_STAT_W-1:0] rd_clr;
  logic [`HPM_STAT_W-1:0] evt;
  logic sclk_rise;
  logic sclk_fall;
  logic lead;
  logic trail;
  logic irq;

  assign pins = {int_n_in, tx_clk_src_sel_b1, tx_mode_sel_b2, tx_mode_sel_b1,
                 a4_cpha_in, a5_cpol_in, tristate_reset_pin, bus_iface_sel, ad_in};

  // ==========================================
  // next state
  always_comb begin
    n = s;
    n.sync1 = pins;
    n.sync2 = s.sync1;
    n.sync3 = s.sync2;
    tst = s.sync2[`HPM_SY_TST];
    tst_rise = tst & ~s.sync3[`HPM_SY_TST];
    bis = s.sync2[`HPM_SY_BIS_HI:`HPM_SY_BIS_LO];
    n.iface = bis;
    n.bus_data = s.sync2[`HPM_SY_AD_HI:0];
    n.ready = 1'b1;
    n.resp = 1'b0;
    n.int_n_val = 1'b0;
    // bus address phase
    ap = hsel & htrans[1] & hready;
    n.dp_wr = ap & hwrite;
    n.dp_addr = haddr[7:0];
    n.hrdata = 32'h0000_0000;
    rd_clr = '0;
    if (ap && !hwrite) begin
      unique case (haddr[7:0])
        `HPM_ADDR_STATUS: begin
          n.hrdata = {27'h0000000, s.status};
          rd_clr = s.status;
        end
        `HPM_ADDR_MASK: n.hrdata = {27'h0000000, s.mask};
        `HPM_ADDR_CTRL: n.hrdata = {31'h00000000, s.int_en};
        `HPM_ADDR_MODE: n.hrdata = {17'h00000, s.tx_clk_src, s.rx_sync_fn, s.tx_sync_fn,
                                    s.tx_mode, s.rx_mode, s.tx_term, s.rx_term, tst, s.iface};
        default: n.hrdata = 32'h0000_0000;
      endcase
    end
    // sticky events, set beats the read clear
    evt = {(bis != s.sync3[`HPM_SY_BIS_HI:`HPM_SY_BIS_LO]) & ~tst, alarm_evt};
    n.status = (s.status & ~rd_clr) | evt;
    if (s.dp_wr) begin
      unique case (s.dp_addr)
        `HPM_ADDR_MASK: n.mask = hwdata[`HPM_STAT_W-1:0];
        `HPM_ADDR_CTRL: n.int_en = hwdata[`HPM_CTRL_INTEN];
        default: n.int_en = s.int_en;
      endcase
    end
    if (tst_rise) begin
      n.status = `HPM_STAT_RST;
      n.mask = `HPM_MASK_RST;
      n.int_en = `HPM_INTEN_RST;
    end
    // serial clock edges, polarity and phase strapped on address pins
    sclk_rise = s.sync2[2] & ~s.sync3[2];
    sclk_fall = ~s.sync2[2] & s.sync3[2];
    lead = s.sync2[`HPM_SY_A5] ? sclk_fall : sclk_rise;
    trail = s.sync2[`HPM_SY_A5] ? sclk_rise : sclk_fall;
    // pin roles per interface
    n.ad_oe = 8'h00;
    n.ad_out = 8'h00;
    n.sclk_sample = 1'b0;
    n.sclk_shift = 1'b0;
    n.mosi = 1'b0;
    n.rx_term = 1'b0;
    n.tx_term = 1'b0;
    n.rx_mode = 3'h0;
    n.tx_mode = 3'h0;
    n.tx_sync_fn = 1'b0;
    n.rx_sync_fn = 1'b0;
    n.tx_clk_src = 2'h0;
    n.jitter_clk = 1'b0;
    unique case (s.iface)
      `HPM_BIS_MUX, `HPM_BIS_NONMUX: begin
        n.ad_oe = {8{par_drive}};
        n.ad_out = par_rd_data;
      end
      `HPM_BIS_SERIAL: begin
        n.ad_oe = 8'h01;
        n.ad_out = {7'h00, spi_miso};
        n.mosi = s.sync2[1];
        n.sclk_sample = s.sync2[`HPM_SY_A4] ? trail : lead;
        n.sclk_shift = s.sync2[`HPM_SY_A4] ? lead : trail;
      end
      `HPM_BIS_HW: begin
        n.rx_term = s.sync2[7];
        n.tx_term = s.sync2[6];
        n.rx_mode = {s.sync2[1], s.sync2[5], s.sync2[4]};
        n.tx_mode = {s.sync2[`HPM_SY_TM2], s.sync2[`HPM_SY_TM1], s.sync2[`HPM_SY_A5]};
        n.tx_sync_fn = s.sync2[3];
        n.rx_sync_fn = s.sync2[2];
        n.tx_clk_src = {s.sync2[`HPM_SY_TCS1], s.sync2[0]};
        n.jitter_clk = s.sync2[`HPM_SY_INT];
      end
    endcase
    irq = (|(s.status & s.mask)) & s.int_en;
    n.int_n_oe = irq & (s.iface != `HPM_BIS_HW);
    if (tst) begin
      n.ad_oe = 8'h00;
      n.int_n_oe = 1'b0;
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.ready <= 1'b1;
      s.int_en <= `HPM_INTEN_RST;
    end else begin
      s <= n;
    end
  end

  // ==========================================
  // outputs
  assign hreadyout = s.ready;
  assign hresp = s.resp;
  assign hrdata = s.hrdata;
  assign ad_out = s.ad_out;
  assign ad_oe = s.ad_oe;
  assign int_n_out = s.int_n_val;
  assign int_n_oe = s.int_n_oe;
  assign iface_mode = s.iface;
  assign bus_data = s.bus_data;
  assign spi_sclk_sample = s.sclk_sample;
  assign spi_sclk_shift = s.sclk_shift;
  assign spi_mosi = s.mosi;
  assign rx_term_disable = s.rx_term;
  assign tx_term_disable = s.tx_term;
  assign rx_mode_sel = s.rx_mode;
  assign tx_mode_sel = s.tx_mode;
  assign tx_sync_fn_sel = s.tx_sync_fn;
  assign rx_sync_fn_sel = s.rx_sync_fn;
  assign tx_clk_src_sel = s.tx_clk_src;
  assign jitter_clk_sel = s.jitter_clk;

  // ==========================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_int_low;
    (|(s.status & s.mask)) && s.int_en && !tst && s.iface != `HPM_BIS_HW
      |=> int_n_oe && !int_n_out;
  endproperty
  a_int_low: assert property (p_int_low) else $error("interrupt not driven");

  property p_int_free;
    !(|(s.status & s.mask)) |=> !int_n_oe;
  endproperty
  a_int_free: assert property (p_int_free) else $error("interrupt held");

  property p_tst_reset;
    tst_rise |=> s.mask == `HPM_MASK_RST && s.int_en == `HPM_INTEN_RST;
  endproperty
  a_tst_reset: assert property (p_tst_reset) else $error("no soft reset");

  property p_tst_hiz;
    tst [*2] |=> ad_oe == 8'h00 && !int_n_oe;
  endproperty
  a_tst_hiz: assert property (p_tst_hiz) else $error("pins driven in tristate");

  property p_iface;
    1'b1 |=> iface_mode == $past(bis);
  endproperty
  a_iface: assert property (p_iface) else $error("mode not followed");

  property p_par;
    s.iface != `HPM_BIS_SERIAL && s.iface != `HPM_BIS_HW && !tst
      |=> ad_oe == {8{$past(par_drive)}} && ad_out == $past(par_rd_data);
  endproperty
  a_par: assert property (p_par) else $error("parallel data wrong");

  property p_hw_term;
    s.iface == `HPM_BIS_HW |=> rx_term_disable == $past(s.sync2[7])
      && tx_term_disable == $past(s.sync2[6]) && ad_oe == 8'h00;
  endproperty
  a_hw_term: assert property (p_hw_term) else $error("termination wrong");

  property p_hw_mode;
    s.iface == `HPM_BIS_HW |=> rx_mode_sel[2] == $past(s.sync2[1])
      && tx_mode_sel[2] == $past(s.sync2[`HPM_SY_TM2]) && rx_sync_fn_sel == $past(s.sync2[2]);
  endproperty
  a_hw_mode: assert property (p_hw_mode) else $error("hardware mode wrong");

  property p_serial;
    s.iface == `HPM_BIS_SERIAL && !tst |=> ad_oe == 8'h01 && ad_out[0] == $past(spi_miso);
  endproperty
  a_serial: assert property (p_serial) else $error("serial out wrong");

  property p_clk_src;
    s.iface == `HPM_BIS_HW |=> tx_clk_src_sel == {$past(s.sync2[`HPM_SY_TCS1]), $past(s.sync2[0])};
  endproperty
  a_clk_src: assert property (p_clk_src) else $error("clock source wrong");

  property p_sclk;
    s.iface == `HPM_BIS_SERIAL && !s.sync2[`HPM_SY_A5] && !s.sync2[`HPM_SY_A4] && sclk_rise
      |=> spi_sclk_sample && !spi_sclk_shift;
  endproperty
  a_sclk: assert property (p_sclk) else $error("sample edge wrong");

  property p_int_en_off;
    !s.int_en |=> !int_n_oe;
  endproperty
  a_int_en_off: assert property (p_int_en_off) else $error("interrupt while disabled");

  property p_hw_int_in;
    s.iface == `HPM_BIS_HW |=> !int_n_oe;
  endproperty
  a_hw_int_in: assert property (p_hw_int_in) else $error("interrupt pin driven in hw mode");

  property p_evt_set;
    (|alarm_evt) && !tst_rise
      |=> (s.status[`HPM_ALARM_W-1:0] & $past(alarm_evt)) == $past(alarm_evt);
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("event not latched");

  property p_tst_status;
    tst_rise |=> s.status == `HPM_STAT_RST;
  endproperty
  a_tst_status: assert property (p_tst_status) else $error("status not reset");

  property p_hw_sync;
    s.iface == `HPM_BIS_HW |=> tx_sync_fn_sel == $past(s.sync2[3])
      && rx_mode_sel[1:0] == $past({s.sync2[5], s.sync2[4]});
  endproperty
  a_hw_sync: assert property (p_hw_sync) else $error("sync or rx mode wrong");

  property p_hw_idle;
    s.iface != `HPM_BIS_HW |=> !rx_term_disable && !tx_term_disable && rx_mode_sel == 3'h0
      && tx_mode_sel == 3'h0 && tx_clk_src_sel == 2'h0 && !jitter_clk_sel;
  endproperty
  a_hw_idle: assert property (p_hw_idle) else $error("strap outputs outside hw mode");

  property p_ser_idle;
    s.iface != `HPM_BIS_SERIAL |=> !spi_sclk_sample && !spi_sclk_shift && !spi_mosi;
  endproperty
  a_ser_idle: assert property (p_ser_idle) else $error("serial outputs outside serial mode");

  property p_mosi;
    s.iface == `HPM_BIS_SERIAL |=> spi_mosi == $past(s.sync2[1]);
  endproperty
  a_mosi: assert property (p_mosi) else $error("serial in wrong");

  property p_sclk_cpha;
    s.iface == `HPM_BIS_SERIAL && !s.sync2[`HPM_SY_A5] && s.sync2[`HPM_SY_A4] && sclk_rise
      |=> spi_sclk_shift && !spi_sclk_sample;
  endproperty
  a_sclk_cpha: assert property (p_sclk_cpha) else $error("shift edge wrong");

  property p_bus_data;
    1'b1 |=> bus_data == $past(s.sync2[`HPM_SY_AD_HI:0]);
  endproperty
  a_bus_data: assert property (p_bus_data) else $error("bus data wrong");

  c_tst: cover property (tst_rise);
  c_irq: cover property (!int_n_oe ##1 int_n_oe);
  c_serial: cover property (s.iface == `HPM_BIS_SERIAL && spi_sclk_sample);
  c_hw: cover property (s.iface == `HPM_BIS_HW ##1 rx_term_disable);
  c_shift: cover property (s.iface == `HPM_BIS_SERIAL && spi_sclk_shift);

endmodule

`default_nettype wire

// >>> common/hpm_regs.svh
`ifndef HPM_REGS_SVH
`define HPM_REGS_SVH

// ==========================================
// register byte offsets
`define HPM_ADDR_STATUS 8'h00
`define HPM_ADDR_MASK 8'h04
`define HPM_ADDR_CTRL 8'h08
`define HPM_ADDR_MODE 8'h0C

// ==========================================
// interface select codes
`define HPM_BIS_MUX 2'h0
`define HPM_BIS_NONMUX 2'h1
`define HPM_BIS_SERIAL 2'h2
`define HPM_BIS_HW 2'h3

// ==========================================
// field layout and reset values
`define HPM_STAT_W 5
`define HPM_ALARM_W 4
`define HPM_STAT_STRAP 4
`define HPM_CTRL_INTEN 0
`define HPM_STAT_RST 5'h00
`define HPM_MASK_RST 5'h00
`define HPM_INTEN_RST 1'h1

// ==========================================
// synchroniser bit positions
`define HPM_SY_W 17
`define HPM_SY_AD_HI 7
`define HPM_SY_BIS_HI 9
`define HPM_SY_BIS_LO 8
`define HPM_SY_TST 10
`define HPM_SY_A5 11
`define HPM_SY_A4 12
`define HPM_SY_TM1 13
`define HPM_SY_TM2 14
`define HPM_SY_TCS1 15
`define HPM_SY_INT 16

`endif

// >>> common/hpm_pkg.sv
`include "hpm_regs.svh"

package hpm_pkg;

  // ==========================================
  // whole state of the pin mux
  typedef struct packed {
    logic [`HPM_SY_W-1:0] sync1;
    logic [`HPM_SY_W-1:0] sync2;
    logic [`HPM_SY_W-1:0] sync3;
    logic [`HPM_STAT_W-1:0] status;
    logic [`HPM_STAT_W-1:0] mask;
    logic int_en;
    logic [1:0] iface;
    logic [7:0] ad_out;
    logic [7:0] ad_oe;
    logic int_n_val;
    logic int_n_oe;
    logic [31:0] hrdata;
    logic ready;
    logic resp;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic rx_term;
    logic tx_term;
    logic [2:0] rx_mode;
    logic [2:0] tx_mode;
    logic tx_sync_fn;
    logic rx_sync_fn;
    logic [1:0] tx_clk_src;
    logic jitter_clk;
    logic [7:0] bus_data;
    logic sclk_sample;
    logic sclk_shift;
    logic mosi;
  } hpm_state_t;

endpackage

// >>> verification/hpm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// host side of the strap and shared pins
module hpm_host_model (
  input wire logic clk,
  input wire logic [1:0] mode,
  input wire logic [7:0] pins,
  input wire logic [7:0] host_oe,
  input wire logic sclk_run,
  input wire logic tst,
  input wire logic cpol,
  input wire logic [7:0] ad_out,
  input wire logic [7:0] ad_oe,
  input wire logic int_n_oe,
  output logic [7:0] ad_in,
  output logic int_n_in,
  output logic [1:0] bus_iface_sel,
  output logic tristate_reset_pin
);
  logic sclk = 1'b0;
  logic flip = 1'b0;
  assign bus_iface_sel = mode;
  assign tristate_reset_pin = tst;
  assign int_n_in = int_n_oe ? 1'b0 : 1'b1;
  always @(posedge clk) flip <= ~flip;
  // serial clock only runs inside a frame, idles at the polarity strap
  always begin
    wait (sclk_run);
    #1.3 sclk = 1'b1;
    #40 sclk = 1'b0;
    #38.7;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ad_oe[i])
        ad_in[i] = ad_out[i];
      else if (host_oe[i])
        ad_in[i] = (i == 2 && mode == 2'h2) ? (sclk ^ cpol) : pins[i];
      else
        ad_in[i] = flip ^ i[0];
    end
  end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hpm_pkg::*;
  logic clk, reset, hsel, hwrite, tst, a5, a4, tm1, tm2, tcs1, pdrv, miso, run;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, mode, im, tcs;
  logic [7:0] pins, hoe, prd, ad_in, ad_out, ad_oe, bdata;
  logic [3:0] alarm;
  logic hro, hresp, int_in, int_out, int_oe, smp, shf, mosi, rxt, txt, tsy, rsy, jck;
  logic [2:0] rxm, txm;
  wire [1:0] bis;
  wire tsp;
  int num_errors = 0, tests_run = 0, cyc = 0, nsamp = 0, nshft = 0, first = 0;
  hpm_host_model host (.clk(clk), .mode(mode), .pins(pins), .host_oe(hoe), .sclk_run(run),
    .tst(tst), .cpol(a5), .ad_out(ad_out), .ad_oe(ad_oe), .int_n_oe(int_oe), .ad_in(ad_in),
    .int_n_in(int_in), .bus_iface_sel(bis), .tristate_reset_pin(tsp));
  hpm_pin_mux dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hro), .hreadyout(hro),
    .hresp(hresp), .hrdata(hrdata), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
    .int_n_in(int_in), .int_n_out(int_out), .int_n_oe(int_oe), .bus_iface_sel(bis),
    .tristate_reset_pin(tsp), .a5_cpol_in(a5), .a4_cpha_in(a4), .tx_mode_sel_b1(tm1),
    .tx_mode_sel_b2(tm2), .tx_clk_src_sel_b1(tcs1), .par_rd_data(prd), .par_drive(pdrv),
    .spi_miso(miso), .alarm_evt(alarm), .iface_mode(im), .bus_data(bdata),
    .spi_sclk_sample(smp), .spi_sclk_shift(shf), .spi_mosi(mosi), .rx_term_disable(rxt),
    .tx_term_disable(txt), .rx_mode_sel(rxm), .tx_mode_sel(txm), .tx_sync_fn_sel(tsy),
    .rx_sync_fn_sel(rsy), .tx_clk_src_sel(tcs), .jitter_clk_sel(jck));
  // ==========
  // clock, timeout, helpers
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (smp === 1'b1) nsamp <= nsamp + 1;
    if (shf === 1'b1) nshft <= nshft + 1;
    if (first == 0 && smp === 1'b1) first <= 1;
    if (first == 0 && shf === 1'b1) first <= 2;
    if (cyc == 6000) begin
      num_errors++;
      results();
    end
  end
  task results;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hro !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hro !== 1'b1);
    r = hrdata;
  endtask
  task rst_on;
    @(posedge clk);
    reset <= 1;
  endtask
  task rst_off;
    repeat (2) @(posedge clk);
    reset <= 0;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ==========
  // scenarios
  task t_hw;
    logic [7:0] v;
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'h4A : 8'hB5;
      rst_on;
      mode <= 2'h3;
      pins <= v;
      hoe <= 8'hFF;
      a5 <= k[0];
      tm1 <= !k[0];
      tm2 <= 1;
      tcs1 <= k[0];
      pdrv <= 1;
      rst_off;
      chk("iface", 2'h3, im);
      chk("ad_oe", 0, ad_oe);
      chk("rxt", v[7], rxt);
      chk("txt", v[6], txt);
      chk("rxm", {v[1], v[5], v[4]}, rxm);
      chk("txm", {1'b1, !k[0], k[0]}, txm);
      chk("tsy", v[3], tsy);
      chk("rsy", v[2], rsy);
      chk("tcs", {k[0], v[0]}, tcs);
      chk("jck", 1, jck);
    end
  endtask
  task t_par;
    for (int m = 0; m < 2; m++) begin
      rst_on;
      mode <= m[1:0];
      a5 <= 0;
      a4 <= 0;
      hoe <= 8'h00;
      pdrv <= 1;
      prd <= 8'hA5 ^ m[7:0];
      rst_off;
      chk("iface", m, im);
      chk("ad_oe", 8'hFF, ad_oe);
      chk("ad_out", 8'hA5 ^ m[7:0], ad_out);
      @(posedge clk);
      pdrv <= 0;
      hoe <= 8'hFF;
      pins <= 8'h3C;
      wt(5);
      chk("ad_oe", 0, ad_oe);
      chk("bdata", 8'h3C, bdata);
    end
  endtask
  task t_spi;
    for (int c = 0; c < 4; c++) begin
      rst_on;
      mode <= 2'h2;
      hoe <= 8'h06;
      pins <= {6'h00, c[0], 1'b0};
      a5 <= c[1];
      a4 <= c[0];
      miso <= c[0];
      rst_off;
      chk("iface", 2'h2, im);
      nsamp = 0;
      nshft = 0;
      first = 0;
      @(posedge clk);
      run <= 1;
      repeat (78) @(posedge clk);
      run <= 0;
      wt(10);
      chk("samples", 4, nsamp);
      chk("shifts", 4, nshft);
      chk("first_edge", c[0] ? 2 : 1, first);
      chk("mosi", c[0], mosi);
      chk("ad_oe", 8'h01, ad_oe);
      chk("miso", c[0], ad_out[0]);
      @(posedge clk);
      miso <= !c[0];
      wt(4);
      chk("miso", !c[0], ad_out[0]);
    end
  endtask
  task t_int;
    rst_on;
    mode <= 2'h1;
    rst_off;
    ahb(1, 8'h04, 32'h1);
    @(posedge clk);
    alarm <= 4'h1;
    @(posedge clk);
    alarm <= 4'h0;
    wt(4);
    chk("int_oe", 1, int_oe);
    chk("int_out", 0, int_out);
    ahb(0, 8'h00, 0);
    chk("status", 1, r[0]);
    wt(4);
    chk("int_oe", 0, int_oe);
    @(posedge clk);
    alarm <= 4'h2;
    @(posedge clk);
    alarm <= 4'h0;
    wt(4);
    chk("masked", 0, int_oe);
    ahb(0, 8'h00, 0);
    chk("status", 1, r[1]);
    ahb(0, 8'h10, 0);
    chk("unmapped", 0, r);
  endtask
  task t_tst;
    @(posedge clk);
    pdrv <= 1;
    tst <= 1;
    wt(6);
    ahb(1, 8'h04, 32'h1F);
    @(posedge clk);
    alarm <= 4'h1;
    @(posedge clk);
    alarm <= 4'h0;
    wt(4);
    chk("ad_oe", 0, ad_oe);
    chk("int_oe", 0, int_oe);
    @(posedge clk);
    tst <= 0;
    wt(6);
    chk("ad_oe", 8'hFF, ad_oe);
    chk("int_oe", 1, int_oe);
    ahb(1, 8'h08, 32'h0);
    @(posedge clk);
    tst <= 1;
    wt(6);
    @(posedge clk);
    tst <= 0;
    wt(6);
    ahb(0, 8'h04, 0);
    chk("mask", 0, r);
    ahb(0, 8'h08, 0);
    chk("ctrl", 1, r);
    ahb(0, 8'h00, 0);
    chk("status", 0, r);
  endtask
  initial begin
    {reset, hsel, hwrite, tst, a5, a4, tm1, tm2, tcs1, pdrv, miso, run} = 12'h800;
    {haddr, hwdata} = 64'h0;
    {htrans, mode, pins, hoe, prd, alarm} = 32'h0;
    repeat (8) @(posedge clk);
    reset <= 0;
    t_hw;
    t_par;
    t_spi;
    t_int;
    t_tst;
    results();
  end
endmodule
`default_nettype wire
